// ---- erase_resp_pkg.sv ----
// Constants and types shared by the chip-erase responder and its testbench
package erase_resp_pkg;
    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int DATA_W     = 8;
    localparam int FIFO_W     = 9;   // Byte plus reception-error flag
    localparam int FIFO_DEPTH = 16;
    localparam int PW_BYTES   = 12;

    typedef logic [PW_BYTES-1:0][DATA_W-1:0] pw_t;

    // ************************************************************
    // Command and answer bytes
    // ************************************************************
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h40;
    localparam logic [7:0] CMD_ERASE_EN   = 8'h54;
    localparam logic [7:0] ACK_OK         = 8'h40;
    localparam logic [7:0] ACK_BAD        = 8'h41;
    localparam logic [7:0] ACK_COMM       = 8'h48;
    localparam logic [7:0] ACK_EN_BAD     = 8'h51;
    localparam logic [7:0] ACK_EN_COMM    = 8'h58;
    localparam logic [7:0] RES_DONE       = 8'h4F;
    localparam logic [7:0] RES_BLANK      = 8'h4C;
    localparam logic [7:0] RES_ABORT      = 8'h47;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [3:0] NIB_BAD        = 4'h1;
    localparam logic [3:0] NIB_COMM       = 4'h8;

    // ************************************************************
    // Reset value, last password index and states
    // ************************************************************
    localparam logic [3:0] RST_CMD_HI = 4'h0;
    localparam logic [3:0] PW_LAST    = 4'hB;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_PW    = 5'b00010,
        ST_CSUM  = 5'b00100,
        ST_EN    = 5'b01000,
        ST_ERASE = 5'b10000
    } resp_state_e;
endpackage

// ---- byte_fifo.sv ----
// Synchronous FIFO with registered full and empty flags
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr, next_wr_ptr;
    logic [PW-1:0]    rd_ptr, next_rd_ptr;
    logic [CW-1:0]    count,  next_count;
    logic             do_wr, do_rd;

    assign do_wr      = in_valid_i && in_ready_o;
    assign do_rd      = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Pointer and occupancy update; depth must be a power of two
    always_comb begin
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        case ({do_wr, do_rd})
            2'b10:   next_count = count + 1'b1;
            2'b01:   next_count = count - 1'b1;
            default: next_count = count;
        endcase
    end

    // Flags are registered from the next count so ports leave a flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            in_ready_o  <= next_count != FULL_CNT;
            out_valid_o <= next_count != '0;
        end
    end

    // Storage array, written without reset
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // byte_fifo

// ---- erase_responder.sv ----
// Boot serial responder for the chip-erase command exchange
// What this block does
// (R1) Checksum byte comms error answers 48, idle
// (R2) Checksum mismatch answers 41, back to idle
// (R3) No password needed: answer 40, continue
// (R4) Password mismatch answers 41, back to idle
// (R5) Password match answers 40, await next byte
// (R6) Host then sends erase-enable byte 54
// (R7) Erase-enable comms error answers 58, idle
// (R8) Wrong erase-enable byte answers 51, idle
// (R9) Correct enable echoes 54, starts erase
// (R10) Erase completed sends result byte 4F
// (R11) Blank check failure sends result 4C
// (R12) Aborted erase sends 47, back to idle
// (R13) Erased flash uses FF as password
// (R14) Host loads routines at RAM 0x2000_0400 upward; no routine download is modelled here
// (R15) Command 40 echoed; X1 unknown, X8 error
// (R16) Host sends twelve password bytes, checksum
// (R17) Error answer high nibble repeats previous command
// (R18) Checksum and password check are replaceable
// (R19) Erase engine: start out, three outcomes in
`timescale 1ns/10ps
module erase_responder (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     rx_valid_i,
    input  wire logic [7:0]               rx_data_i,
    input  wire logic                     rx_err_i,
    output logic                          rx_ready_o,
    output logic                          tx_valid_o,
    output logic      [7:0]               tx_data_o,
    input  wire logic                     tx_ready_i,
    input  wire logic                     pw_required_i,
    input  wire logic                     flash_erased_i,
    input  wire erase_resp_pkg::pw_t      stored_pw_i,
    output logic                          erase_start_o,
    input  wire logic                     erase_done_i,
    input  wire logic                     erase_blank_fail_i,
    input  wire logic                     erase_abort_i,
    output logic                          busy_o
);
    import erase_resp_pkg::*;

    // ************************************************************
    // Replaceable check functions
    // ************************************************************
    // (R18) checksum check point
    // Sum of all password bytes plus the checksum byte must wrap to zero
    function automatic logic csum_ok_f(input pw_t b, input logic [7:0] s);
        logic [7:0] acc;
        acc = s;
        for (int i = 0; i < PW_BYTES; i++) begin
            acc = acc + b[i];
        end
        return acc == 8'h00;
    endfunction

    // (R18) password check point
    function automatic logic pw_match_f(input pw_t rx, input pw_t ref_pw);
        return rx == ref_pw;
    endfunction

    // ************************************************************
    // Receive FIFO
    // ************************************************************
    logic              f_valid;
    logic              f_ready;
    logic [FIFO_W-1:0] f_word;
    logic [7:0]        f_data;
    logic              f_err;

    byte_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (rx_valid_i),
        .in_data_i   ({rx_err_i, rx_data_i}),
        .in_ready_o  (rx_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_word),
        .out_ready_i (f_ready)
    );

    assign f_data = f_word[7:0];
    assign f_err  = f_word[8];

    // ************************************************************
    // Exchange sequencer
    // ************************************************************
    resp_state_e state, next_state;
    pw_t         pw_buf;
    pw_t         pw_ref;
    logic [3:0]  cnt, next_cnt;
    logic [3:0]  cmd_hi, next_cmd_hi;
    logic        pw_err, next_pw_err;
    logic        next_tx_valid;
    logic [7:0]  next_tx_data;
    logic        next_start;
    logic        pw_we;
    logic        take;
    logic        eng_ok;

    // A byte is taken only when the answer register is free, so a slow
    // host stalls the FIFO and finally the serial receiver
    assign take    = f_valid && !tx_valid_o && state != ST_ERASE;
    assign f_ready = take;
    assign eng_ok  = !tx_valid_o && !erase_start_o;

    // (R13) erased flash password
    assign pw_ref = flash_erased_i ? {PW_BYTES{ERASED_BYTE}} : stored_pw_i;

    // Next state and answer byte
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_cmd_hi   = cmd_hi;
        next_pw_err   = pw_err;
        next_tx_valid = tx_valid_o && !tx_ready_i;
        next_tx_data  = tx_data_o;
        next_start    = 1'b0;
        pw_we         = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_tx_valid = 1'b1;
                    // (R15) command byte check
                    if (f_err) begin
                        // (R17) stale nibble kept
                        next_tx_data = {cmd_hi, NIB_COMM};
                    end else if (f_data != CMD_CHIP_ERASE) begin
                        next_cmd_hi  = f_data[7:4];
                        next_tx_data = {cmd_hi, NIB_BAD};
                    end else begin
                        next_cmd_hi  = f_data[7:4];
                        next_tx_data = CMD_CHIP_ERASE;
                        next_state   = ST_PW;
                        next_cnt     = '0;
                        next_pw_err  = 1'b0;
                    end
                end
            end
            ST_PW: begin
                // (R16) twelve password bytes
                if (take) begin
                    pw_we       = 1'b1;
                    next_pw_err = pw_err || f_err;
                    next_cnt    = cnt + 1'b1;
                    if (cnt == PW_LAST) begin
                        next_state = ST_CSUM;
                    end
                end
            end
            ST_CSUM: begin
                if (take) begin
                    next_tx_valid = 1'b1;
                    next_state    = ST_IDLE;
                    // (R1) comms error answer
                    if (f_err || pw_err) begin
                        next_tx_data = ACK_COMM;
                    // (R2) checksum mismatch
                    end else if (!csum_ok_f(pw_buf, f_data)) begin
                        next_tx_data = ACK_BAD;
                    // (R3) password not required
                    end else if (!pw_required_i) begin
                        next_tx_data = ACK_OK;
                        next_state   = ST_EN;
                    // (R4) password mismatch
                    end else if (!pw_match_f(pw_buf, pw_ref)) begin
                        next_tx_data = ACK_BAD;
                    // (R5) password accepted
                    end else begin
                        next_tx_data = ACK_OK;
                        next_state   = ST_EN;
                    end
                end
            end
            ST_EN: begin
                if (take) begin
                    next_tx_valid = 1'b1;
                    next_state    = ST_IDLE;
                    // (R7) enable comms error
                    if (f_err) begin
                        next_tx_data = ACK_EN_COMM;
                    // (R8) wrong enable byte
                    end else if (f_data != CMD_ERASE_EN) begin
                        next_tx_data = ACK_EN_BAD;
                    // (R9) echo and start erase
                    end else begin
                        next_tx_data = CMD_ERASE_EN;
                        next_start   = 1'b1;
                        next_state   = ST_ERASE;
                    end
                end
            end
            ST_ERASE: begin
                // (R19) engine outcome mapping
                if (eng_ok && (erase_abort_i || erase_blank_fail_i || erase_done_i)) begin
                    next_tx_valid = 1'b1;
                    next_state    = ST_IDLE;
                    // (R12) abort wins over the rest
                    if (erase_abort_i) begin
                        next_tx_data = RES_ABORT;
                    // (R11) blank check failure
                    end else if (erase_blank_fail_i) begin
                        next_tx_data = RES_BLANK;
                    // (R10) clean completion
                    end else begin
                        next_tx_data = RES_DONE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state         <= ST_IDLE;
            cnt           <= '0;
            cmd_hi        <= RST_CMD_HI;
            pw_err        <= 1'b0;
            tx_valid_o    <= 1'b0;
            tx_data_o     <= '0;
            erase_start_o <= 1'b0;
            busy_o        <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            cmd_hi        <= next_cmd_hi;
            pw_err        <= next_pw_err;
            tx_valid_o    <= next_tx_valid;
            tx_data_o     <= next_tx_data;
            erase_start_o <= next_start;
            busy_o        <= next_state != ST_IDLE;
        end
    end

    // Password bytes, first received in index 0
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pw_buf <= '0;
        end else if (pw_we) begin
            pw_buf[cnt] <= f_data;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic tk_cmd, tk_csum, tk_en, csum_good;
    assign tk_cmd    = take && state == ST_IDLE;
    assign tk_csum   = take && state == ST_CSUM;
    assign tk_en     = take && state == ST_EN;
    assign csum_good = tk_csum && !f_err && !pw_err && csum_ok_f(pw_buf, f_data);

    csum_comm_a: assert property (tk_csum && f_err |=> // (R1)
        tx_valid_o && tx_data_o == 8'h48 && state == ST_IDLE)
        else $error("checksum comms error answer wrong");
    csum_bad_a: assert property (tk_csum && !f_err && !pw_err && // (R2)
        !csum_ok_f(pw_buf, f_data) |=> tx_data_o == 8'h41 && state == ST_IDLE)
        else $error("checksum mismatch answer wrong");
    nopw_pass_a: assert property (csum_good && !pw_required_i |=> // (R3)
        tx_data_o == 8'h40 && state == ST_EN)
        else $error("no-password path wrong");
    pw_bad_a: assert property (csum_good && pw_required_i && // (R4)
        !pw_match_f(pw_buf, pw_ref) |=> tx_data_o == 8'h41 && state == ST_IDLE)
        else $error("password mismatch answer wrong");
    pw_good_a: assert property (csum_good && pw_required_i && // (R5)
        pw_match_f(pw_buf, pw_ref) |=> tx_data_o == 8'h40 && state == ST_EN)
        else $error("password match answer wrong");
    en_comm_a: assert property (tk_en && f_err |=> // (R7)
        tx_data_o == 8'h58 && state == ST_IDLE)
        else $error("enable comms answer wrong");
    en_bad_a: assert property (tk_en && !f_err && f_data != 8'h54 |=> // (R8)
        tx_data_o == 8'h51 && !erase_start_o)
        else $error("wrong enable answer wrong");
    erase_go_a: assert property (tk_en && !f_err && f_data == 8'h54 |=> // (R9)
        tx_data_o == 8'h54 && erase_start_o ##1 !erase_start_o)
        else $error("erase start wrong");
    done_res_a: assert property (state == ST_ERASE && eng_ok && erase_done_i && // (R10)
        !erase_abort_i && !erase_blank_fail_i |=> tx_data_o == 8'h4F)
        else $error("completion result wrong");
    blank_res_a: assert property (state == ST_ERASE && eng_ok && erase_blank_fail_i && // (R11)
        !erase_abort_i |=> tx_data_o == 8'h4C)
        else $error("blank fail result wrong");
    abort_res_a: assert property (state == ST_ERASE && eng_ok && erase_abort_i |=> // (R12)
        tx_data_o == 8'h47 && state == ST_IDLE)
        else $error("abort result wrong");
    cmd_err_a: assert property (take && state == ST_IDLE && f_err |=> // (R17)
        tx_data_o == {$past(cmd_hi), 4'h8} && state == ST_IDLE)
        else $error("command error answer wrong");
    cmd_echo_a: assert property (tk_cmd && !f_err && f_data == 8'h40 |=> // (R15)
        tx_valid_o && tx_data_o == 8'h40 && state == ST_PW)
        else $error("command echo wrong");
    cmd_unk_a: assert property (tk_cmd && !f_err && f_data != 8'h40 |=> // (R15)
        tx_data_o[3:0] == 4'h1 && state == ST_IDLE)
        else $error("unknown command answer wrong");
    pw_quiet_a: assert property (take && state == ST_PW |=> // (R16)
        !tx_valid_o)
        else $error("password byte answered");
    erased_pw_a: assert property (csum_good && pw_required_i && flash_erased_i && // (R13)
        pw_buf == {PW_BYTES{8'hFF}} |=> tx_data_o == 8'h40 && state == ST_EN)
        else $error("erased password refused");
    start_src_a: assert property (erase_start_o |-> // (R19)
        state == ST_ERASE && $past(state) == ST_EN)
        else $error("erase start outside enable");

    erase_done_c: cover property (state == ST_ERASE ##1 tx_valid_o && tx_data_o == 8'h4F);
    cmd_bad_c: cover property (take && state == ST_IDLE && !f_err && f_data != 8'h40);
    fifo_full_c: cover property (!rx_ready_o ##1 rx_ready_o);
    pw_erased_c: cover property (csum_good && pw_required_i && flash_erased_i);
    tx_stall_c: cover property (tx_valid_o && !tx_ready_i ##1 tx_valid_o);
endmodule // erase_responder

// ---- host_link_model.sv ----
// Host controller model: presents request bytes and gathers answer bytes
`timescale 1ns/10ps
module host_link_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       rx_ready_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    output logic            rx_err_o,
    output logic            tx_ready_o
);
    logic       stall = 1'b0; // Bench raises it to hold answers back
    logic       slow  = 1'b0;
    logic       phase;
    logic [7:0] ans_q[$];

    // Quiet line at time zero
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        rx_err_o   = 1'b0;
    end

    // Answer is taken only at an edge where valid and ready meet
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ready_o <= 1'b0;
            phase      <= 1'b0;
        end else begin
            if (tx_valid_i && tx_ready_o) begin
                ans_q.push_back(tx_data_i);
            end
            phase      <= !phase;
            tx_ready_o <= !stall && !(slow && phase); // Slow mode takes every other cycle
        end
    end

    // no routine download here
    // Byte held with its error flag until the edge where ready is high
    task automatic send_byte(input logic [7:0] d, input logic e);
        rx_valid_o <= 1'b1;
        rx_data_o  <= d;
        rx_err_o   <= e;
        do @(negedge clk_i); while (!rx_ready_i);
        @(posedge clk_i);
    endtask

    // Released line shows the inverse, so a stale byte never looks valid
    task automatic release_line();
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
        rx_err_o   <= ~rx_err_o;
    endtask
endmodule // host_link_model

// ---- tb_erase_responder.sv ----
// Self-checking bench for the chip-erase responder
`timescale 1ns/10ps
module tb_erase_responder;
    import erase_resp_pkg::*;
    logic       clk_i;
    logic       rst_n_i;
    logic       rx_valid, rx_err, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic       pw_required, flash_erased, erase_start, busy;
    logic       erase_done = 1'b0, erase_blank_fail = 1'b0, erase_abort = 1'b0;
    pw_t        stored_pw;
    pw_t        pw_ff;
    int         outcome, num_errors, checks_done;
    int         eng_cnt = 0, starts = 0;
    logic [7:0] exp_q[$];

    erase_responder dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_err_i(rx_err), .rx_ready_o(rx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .pw_required_i(pw_required), .flash_erased_i(flash_erased),
        .stored_pw_i(stored_pw), .erase_start_o(erase_start), .erase_done_i(erase_done),
        .erase_blank_fail_i(erase_blank_fail), .erase_abort_i(erase_abort), .busy_o(busy));
    host_link_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_ready_i(rx_ready),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_err_o(rx_err), .tx_ready_o(tx_ready));

    initial clk_i = 1'b0;
    always #12.5 clk_i = ~clk_i;

    // Erase engine stand-in: stale outcome dropped at start, new one after a delay
    always @(posedge clk_i) begin
        if (erase_start) begin
            {erase_done, erase_blank_fail, erase_abort} <= 3'b000;
            eng_cnt <= 6;
            starts  <= starts + 1;
        end else if (eng_cnt == 1) begin
            eng_cnt          <= 0;
            erase_done       <= (outcome == 0);
            erase_blank_fail <= (outcome == 1);
            erase_abort      <= (outcome == 2);
        end else if (eng_cnt > 1) begin
            eng_cnt <= eng_cnt - 1;
        end
    end

    // ****************************************************
    // Compare and helper tasks
    // ****************************************************
    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_num(input string what, input int e, input int g);
        checks_done++;
        if (g != e) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, e, g);
        end
    endtask

    // Waits for the expected answers under a bound, then judges order and idle
    task automatic finish_test(input string name);
        int w;
        w = 0;
        while (host.ans_q.size() < exp_q.size() && w < 600) begin
            @(posedge clk_i);
            w++;
        end
        repeat (4) @(posedge clk_i);
        check_num({name, " answers"}, exp_q.size(), host.ans_q.size());
        foreach (exp_q[i])
            if (i < host.ans_q.size())
                check_byte({name, " answer"}, exp_q[i], host.ans_q[i]);
        check_bit({name, " idle"}, 1'b0, busy);
        exp_q.delete();
        host.ans_q.delete();
        $display("test %s done", name);
    endtask

    // Command, password bytes, checksum and optionally the enable byte
    task automatic run_seq(input pw_t p, input logic [7:0] adj, input logic cs_err,
                           input logic go_on, input logic [7:0] en, input logic en_err);
        logic [7:0] sum;
        sum = 8'h00;
        host.send_byte(CMD_CHIP_ERASE, 1'b0);
        for (int i = 0; i < PW_BYTES; i++) begin
            host.send_byte(p[i], 1'b0);
            sum = sum + p[i];
        end
        host.send_byte(8'h00 - sum + adj, cs_err);
        if (go_on) host.send_byte(en, en_err);
        host.release_line();
    endtask

    task automatic erase_run(input string name, input pw_t p, input int oc, input logic [7:0] r);
        int s0;
        s0      = starts;
        outcome = oc;
        run_seq(p, 8'h00, 1'b0, 1'b1, CMD_ERASE_EN, 1'b0);
        exp_q.push_back(CMD_CHIP_ERASE);
        exp_q.push_back(ACK_OK);
        exp_q.push_back(CMD_ERASE_EN);
        exp_q.push_back(r);
        finish_test(name);
        check_num({name, " starts"}, s0 + 1, starts);
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_cmd();
        host.send_byte(8'h23, 1'b0);
        host.send_byte(8'h9A, 1'b1);
        host.send_byte(8'h77, 1'b0);
        host.release_line();
        exp_q.push_back({RST_CMD_HI, NIB_BAD});
        exp_q.push_back({4'h2, NIB_COMM});
        exp_q.push_back({4'h2, NIB_BAD});
        finish_test("bad command");
    endtask
    task automatic t_fifo();
        host.stall = 1'b1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 17; i++) host.send_byte(8'h23, 1'b0);
        fork
            host.send_byte(8'h23, 1'b0);
            begin
                repeat (4) @(negedge clk_i);
                check_bit("full fifo ready", 1'b0, rx_ready);
                host.stall = 1'b0;
            end
        join
        host.release_line();
        exp_q.push_back({4'h7, NIB_BAD});
        repeat (17) exp_q.push_back({4'h2, NIB_BAD});
        finish_test("fifo fill");
    endtask
    task automatic t_pw_ok();
        pw_required <= 1'b1;
        erase_run("password match", stored_pw, 0, RES_DONE);
    endtask
    task automatic t_no_pw();
        pw_required <= 1'b0;
        erase_run("no password", ~stored_pw, 1, RES_BLANK);
    endtask
    task automatic t_erased();
        pw_required  <= 1'b1;
        flash_erased <= 1'b1;
        host.slow = 1'b1;
        erase_run("erased flash", pw_ff, 2, RES_ABORT);
        host.slow = 1'b0;
        flash_erased <= 1'b0;
    endtask
    task automatic t_csum();
        run_seq(stored_pw, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        exp_q = '{CMD_CHIP_ERASE, ACK_COMM};
        finish_test("checksum error flag");
        run_seq(stored_pw, 8'h01, 1'b0, 1'b0, 8'h00, 1'b0);
        exp_q = '{CMD_CHIP_ERASE, ACK_BAD};
        finish_test("checksum mismatch");
    endtask
    task automatic t_pw_bad();
        pw_t p;
        p    = stored_pw;
        p[5] = p[5] ^ 8'h10;
        run_seq(p, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        exp_q = '{CMD_CHIP_ERASE, ACK_BAD};
        finish_test("password mismatch");
    endtask
    task automatic t_enable();
        int s0;
        s0 = starts;
        run_seq(stored_pw, 8'h00, 1'b0, 1'b1, CMD_ERASE_EN, 1'b1);
        exp_q = '{CMD_CHIP_ERASE, ACK_OK, ACK_EN_COMM};
        finish_test("enable error flag");
        run_seq(stored_pw, 8'h00, 1'b0, 1'b1, 8'h55, 1'b0);
        exp_q = '{CMD_CHIP_ERASE, ACK_OK, ACK_EN_BAD};
        finish_test("enable wrong byte");
        check_num("no erase started", s0, starts);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence: reset, then every scenario in turn
    initial begin
        rst_n_i = 1'b0;
        {pw_required, flash_erased} = 2'b00;
        {outcome, num_errors, checks_done} = {3{32'sd0}};
        for (int i = 0; i < PW_BYTES; i++) stored_pw[i] = 8'(8'h30 + 7 * i);
        pw_ff = {PW_BYTES{ERASED_BYTE}};
        repeat (20) @(posedge clk_i);
        check_bit("reset ready", 1'b1, rx_ready);
        check_bit("reset tx valid", 1'b0, tx_valid);
        check_bit("reset start", 1'b0, erase_start);
        check_bit("reset busy", 1'b0, busy);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_cmd();
        t_fifo();
        t_pw_ok();
        t_no_pw();
        t_erased();
        t_csum();
        t_pw_bad();
        t_enable();
        give_verdict();
    end

    // Watchdog far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule // tb_erase_responder
